// *** hw/serial_channel_pkg.sv ***
// Constants, register map and state types for the serial channel
package serial_channel_pkg;

  // Register offsets
  localparam logic [2:0] ADDR_MODE   = 3'h0;
  localparam logic [2:0] ADDR_CTRL   = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_TXDATA = 3'h3;
  localparam logic [2:0] ADDR_RXDATA = 3'h4;
  localparam logic [2:0] ADDR_BAUD   = 3'h5;

  // serial_mode_reg fields
  localparam int MODE_SYNC_BIT    = 7;
  localparam int MODE_PAR_EN_BIT  = 5;
  localparam int MODE_PAR_ODD_BIT = 4;
  localparam int MODE_MP_BIT      = 2;

  // serial_control_reg fields
  localparam int CTRL_TXIE_BIT  = 7;
  localparam int CTRL_RXIE_BIT  = 6;
  localparam int CTRL_TXEN_BIT  = 5;
  localparam int CTRL_RXEN_BIT  = 4;
  localparam int CTRL_MPW_BIT   = 3;
  localparam int CTRL_TX_END_IRQ_EN_BIT  = 2;
  localparam int CTRL_CKHI_BIT  = 1;
  localparam int CTRL_CKLO_BIT  = 0;

  // serial_status_reg fields
  localparam int STAT_TX_BUFFER_EMPTY_FLAG_BIT = 7;
  localparam int STAT_RX_FULL_FLAG_BIT = 6;
  localparam int STAT_OVR_BIT  = 5;
  localparam int STAT_FER_BIT  = 4;
  localparam int STAT_PER_BIT  = 3;
  localparam int STAT_TX_END_FLAG_BIT = 2;
  localparam int STAT_MPBR_BIT = 1;
  localparam int STAT_MP_BIT_TO_SEND_BIT = 0;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // Frame timing
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [3:0] OS_LAST    = 4'hf;
  localparam logic [3:0] OS_MID     = 4'h7;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP} tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} rx_state_type;

endpackage

// *** hw/pin_sync.sv ***
// Two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/1ns
module pin_sync #(
  parameter int         WIDTH     = 2,
  parameter logic [1:0] RESET_VAL = 2'h3
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // Pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // First stage feeds the second stage only
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          meta_reg <= RESET_VAL[g];
          sync_reg <= RESET_VAL[g];
        end
        else
        begin
          meta_reg <= i_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[g] = sync_reg;
    end
  endgenerate

endmodule

// *** hw/baud_tick.sv ***
// Divider that gives one tick every divisor+1 system clocks
`timescale 1ns/1ns
module baud_tick (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Control
  input  wire logic       i_run,
  input  wire logic [7:0] i_divisor,
  // Tick pulse
  output logic            o_tick
);

  logic [7:0] cnt_reg;
  logic       tick_reg;
  wire        wrap = (cnt_reg >= i_divisor);

  // Held in reset while stopped so the first tick is a full period away
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= (!i_run || wrap) ? 8'h00 : cnt_reg + 8'h01;
      tick_reg <= i_run && wrap;
    end
  end

  assign o_tick = tick_reg;

endmodule

// *** hw/serial_channel.sv ***
// Serial channel: synchronous and asynchronous multiprocessor transfer
`timescale 1ns/1ns
module serial_channel
  import serial_channel_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Serial pins
  input  wire logic       i_sck,
  output logic            o_sck,
  output logic            o_sck_oe_b,
  input  wire logic       i_rxd,
  output logic            o_txd,
  // Interrupt requests
  output logic            o_tx_empty_irq,
  output logic            o_tx_end_irq,
  output logic            o_rx_full_irq,
  output logic            o_rx_error_irq
);

  // Register file
  logic [7:0] serial_mode_reg;
  logic [7:0] serial_control_reg;
  logic [7:0] baud_div_reg;
  logic [7:0] tx_holding_reg;
  logic [7:0] rx_holding_reg;
  logic [7:0] rdata_reg;
  logic       tx_buffer_empty_flag;
  logic       tx_end_flag;
  logic       rx_full_flag;
  logic       overrun_flag;
  logic       framing_err_flag;
  logic       parity_err_flag;
  logic       mp_bit_to_send;
  logic       mp_bit_rx_reg;

  // Datapath
  logic [7:0]   tx_shift_reg;
  logic [7:0]   rx_shift_reg;
  logic         txd_reg;
  logic         txd_next;
  logic         sck_out_reg;
  logic         sck_prev_reg;
  logic         sync_busy_reg;
  logic         sync_tx_reg;
  logic [2:0]   sync_cnt_reg;
  tx_state_type tx_state_reg;
  tx_state_type tx_state_next;
  logic [3:0]   tx_os_reg;
  logic [2:0]   tx_bit_reg;
  logic         tx_extra_reg;
  rx_state_type rx_state_reg;
  rx_state_type rx_state_next;
  logic [3:0]   rx_os_reg;
  logic [2:0]   rx_bit_reg;
  logic         rx_extra_reg;

  // Pin synchronisers
  logic [1:0] pins_sync;
  logic       tick;

  pin_sync #(
    .WIDTH     (2),
    .RESET_VAL (2'h3)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_rxd, i_sck}),
    .o_sync  (pins_sync)
  );

  wire sck_s = pins_sync[0];
  wire rxd_s = pins_sync[1];

  // Mode decode
  wire sync_mode = serial_mode_reg[MODE_SYNC_BIT];
  wire mp_fmt    = serial_mode_reg[MODE_MP_BIT] && !sync_mode;
  wire par_on    = serial_mode_reg[MODE_PAR_EN_BIT] && !mp_fmt && !sync_mode;
  wire par_odd   = serial_mode_reg[MODE_PAR_ODD_BIT];
  wire extra_on  = mp_fmt || par_on;
  wire tx_en     = serial_control_reg[CTRL_TXEN_BIT];
  wire rx_en     = serial_control_reg[CTRL_RXEN_BIT];
  wire mp_wait   = serial_control_reg[CTRL_MPW_BIT];
  wire ext_clk   = serial_control_reg[CTRL_CKHI_BIT];
  wire clk_out   = sync_mode && !ext_clk && (tx_en || rx_en);
  wire err_any   = overrun_flag || framing_err_flag || parity_err_flag;

  // Bus decode
  wire wr_mode   = i_wr && (i_addr == ADDR_MODE);
  wire wr_ctrl   = i_wr && (i_addr == ADDR_CTRL);
  wire wr_stat   = i_wr && (i_addr == ADDR_STATUS);
  wire wr_tdr    = i_wr && (i_addr == ADDR_TXDATA);
  wire wr_baud   = i_wr && (i_addr == ADDR_BAUD);
  wire rd_rdr    = i_rd && (i_addr == ADDR_RXDATA);
  wire [7:0] status_val = {tx_buffer_empty_flag, rx_full_flag, overrun_flag,
                           framing_err_flag, parity_err_flag, tx_end_flag,
                           mp_bit_rx_reg, mp_bit_to_send};

  baud_tick u_baud_tick (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (tx_en || rx_en),
    .i_divisor (baud_div_reg),
    .o_tick    (tick)
  );

  // Edge finding on the synchronised clock pin
  wire sck_rise = sck_s && !sck_prev_reg;
  wire sck_fall = !sck_s && sck_prev_reg;
  wire a_tick   = ext_clk ? sck_rise : tick;

  // A load never races a write of the holding register
  wire tx_ready = tx_en && !tx_buffer_empty_flag && !wr_tdr;

  // Synchronous engine
  wire s_tx_go  = tx_ready && !err_any;
  wire s_start  = sync_mode && !sync_busy_reg && (s_tx_go || (rx_en && !tx_en && !err_any));
  wire s_fall   = sync_busy_reg && (ext_clk ? sck_fall : (tick && sck_out_reg));
  wire s_rise   = sync_busy_reg && (ext_clk ? sck_rise : (tick && !sck_out_reg));
  wire s_end    = s_rise && (sync_cnt_reg == LAST_BIT);
  wire s_next   = s_end && sync_tx_reg && s_tx_go;
  wire s_tx_end = s_end && sync_tx_reg && !s_next;

  // Asynchronous transmit events
  wire a_os_end   = a_tick && (tx_os_reg == OS_LAST);
  wire a_tx_start = !sync_mode && (tx_state_reg == TX_IDLE) && tx_ready;
  wire a_stop_end = (tx_state_reg == TX_STOP) && a_os_end;
  wire a_tx_next  = a_stop_end && tx_ready;
  wire a_tx_end   = a_stop_end && !tx_ready;
  wire tx_load    = (s_start && s_tx_go) || s_next || a_tx_start || a_tx_next;

  // Asynchronous receive events
  wire r_os_end  = a_tick && (rx_os_reg == OS_LAST);
  wire a_rx_done = (rx_state_reg == RX_STOP) && r_os_end;

  // Receive completion, shared by both modes
  wire [7:0] rx_byte = sync_mode ? {rxd_s, rx_shift_reg[7:1]} : rx_shift_reg;
  wire rx_done   = (s_end && rx_en) || a_rx_done;
  wire rx_skip   = a_rx_done && mp_fmt && mp_wait && !rx_extra_reg;
  wire rx_accept = rx_done && !rx_skip;
  wire rx_store  = rx_accept && !rx_full_flag;
  wire ovr_set   = rx_accept && rx_full_flag;
  wire fer_set   = rx_accept && a_rx_done && !rxd_s;
  wire per_set   = rx_accept && a_rx_done && par_on
                   && ((^rx_shift_reg ^ rx_extra_reg) != par_odd);
  wire id_taken  = rx_accept && mp_fmt && rx_extra_reg;

  // Control registers
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      serial_mode_reg    <= MODE_RST;
      serial_control_reg <= CTRL_RST;
      baud_div_reg       <= BAUD_RST;
      tx_holding_reg     <= 8'h00;
    end
    else
    begin
      if (wr_mode)
        serial_mode_reg <= i_wdata;
      if (wr_baud)
        baud_div_reg <= i_wdata;
      if (wr_tdr)
        tx_holding_reg <= i_wdata;
      if (wr_ctrl)
        serial_control_reg <= i_wdata;
      else if (id_taken)
        serial_control_reg[CTRL_MPW_BIT] <= 1'b0;
    end
  end

  // Transmit flags; hardware sets win over clears
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_buffer_empty_flag <= 1'b1;
      tx_end_flag          <= 1'b1;
      mp_bit_to_send       <= 1'b0;
    end
    else
    begin
      if (tx_load || !tx_en)
        tx_buffer_empty_flag <= 1'b1;
      else if (wr_tdr)
        tx_buffer_empty_flag <= 1'b0;
      if (s_tx_end || a_tx_end || !tx_en)
        tx_end_flag <= 1'b1;
      else if (wr_tdr)
        tx_end_flag <= 1'b0;
      if (wr_stat)
        mp_bit_to_send <= i_wdata[STAT_MP_BIT_TO_SEND_BIT];
    end
  end

  // Receive flags: software clears by writing zero; a clear of any error
  // flag is refused in the cycle that flag is set again
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_full_flag     <= 1'b0;
      overrun_flag     <= 1'b0;
      framing_err_flag <= 1'b0;
      parity_err_flag  <= 1'b0;
      mp_bit_rx_reg    <= 1'b0;
      rx_holding_reg   <= 8'h00;
    end
    else
    begin
      if (rx_store)
        rx_full_flag <= 1'b1;
      else if (rd_rdr || (wr_stat && !i_wdata[STAT_RX_FULL_FLAG_BIT]))
        rx_full_flag <= 1'b0;
      if (ovr_set)
        overrun_flag <= 1'b1;
      else if (wr_stat && !i_wdata[STAT_OVR_BIT])
        overrun_flag <= 1'b0;
      if (fer_set)
        framing_err_flag <= 1'b1;
      else if (wr_stat && !i_wdata[STAT_FER_BIT])
        framing_err_flag <= 1'b0;
      if (per_set)
        parity_err_flag <= 1'b1;
      else if (wr_stat && !i_wdata[STAT_PER_BIT])
        parity_err_flag <= 1'b0;
      if (rx_store)
      begin
        rx_holding_reg <= rx_byte;
        mp_bit_rx_reg  <= mp_fmt && rx_extra_reg;
      end
    end
  end

  // Read port: data stand for exactly one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rdata_reg <= 8'h00;
    else if (!i_rd)
      rdata_reg <= 8'h00;
    else
    begin
      case (i_addr)
        ADDR_MODE:   rdata_reg <= serial_mode_reg;
        ADDR_CTRL:   rdata_reg <= serial_control_reg;
        ADDR_STATUS: rdata_reg <= status_val;
        ADDR_TXDATA: rdata_reg <= tx_holding_reg;
        ADDR_RXDATA: rdata_reg <= rx_holding_reg;
        ADDR_BAUD:   rdata_reg <= baud_div_reg;
        default:     rdata_reg <= 8'h00;
      endcase
    end
  end

  // Synchronous engine state
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync_busy_reg <= 1'b0;
      sync_tx_reg   <= 1'b0;
      sync_cnt_reg  <= 3'h0;
      sck_out_reg   <= 1'b1;
      sck_prev_reg  <= 1'b1;
    end
    else
    begin
      sck_prev_reg <= sck_s;
      if (s_start)
      begin
        sync_busy_reg <= 1'b1;
        sync_tx_reg   <= s_tx_go;
        sync_cnt_reg  <= 3'h0;
      end
      else if (!sync_mode || !(tx_en || rx_en))
        sync_busy_reg <= 1'b0;
      else if (s_end)
      begin
        sync_busy_reg <= s_next;
        sync_tx_reg   <= s_next;
        sync_cnt_reg  <= 3'h0;
      end
      else if (s_rise)
        sync_cnt_reg <= sync_cnt_reg + 3'h1;
      // Clock idles high; a frame's last rise returns it there
      if (!clk_out || !sync_busy_reg)
        sck_out_reg <= 1'b1;
      else if (s_fall || s_rise)
        sck_out_reg <= !sck_out_reg;
    end
  end

  // Asynchronous transmit sequencer
  always_comb
  begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      TX_IDLE:
        if (a_tx_start)
          tx_state_next = TX_START;
      TX_START:
        if (a_os_end)
          tx_state_next = TX_DATA;
      TX_DATA:
        if (a_os_end && tx_bit_reg == LAST_BIT)
          tx_state_next = extra_on ? TX_EXTRA : TX_STOP;
      TX_EXTRA:
        if (a_os_end)
          tx_state_next = TX_STOP;
      TX_STOP:
        if (a_stop_end)
          tx_state_next = a_tx_next ? TX_START : TX_IDLE;
      default:
        tx_state_next = TX_IDLE;
    endcase
    if (!tx_en || sync_mode)
      tx_state_next = TX_IDLE;
  end

  // Line level: async idles at mark, sync holds the last bit
  always_comb
  begin
    case (tx_state_reg)
      TX_START: txd_next = 1'b0;
      TX_DATA:  txd_next = tx_shift_reg[0];
      TX_EXTRA: txd_next = tx_extra_reg;
      default:  txd_next = 1'b1;
    endcase
    if (!tx_en)
      txd_next = 1'b1;
    else if (sync_mode)
      txd_next = (s_fall && sync_tx_reg) ? tx_shift_reg[0] : txd_reg;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_state_reg <= TX_IDLE;
      tx_os_reg    <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_extra_reg <= 1'b0;
      tx_shift_reg <= 8'h00;
      txd_reg      <= 1'b1;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      txd_reg      <= txd_next;
      if (tx_load)
      begin
        tx_shift_reg <= tx_holding_reg;
        tx_extra_reg <= mp_fmt ? mp_bit_to_send : (^tx_holding_reg ^ par_odd);
        tx_os_reg    <= 4'h0;
        tx_bit_reg   <= 3'h0;
      end
      else if (s_fall && sync_tx_reg)
        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
      else if (a_tick && tx_state_reg != TX_IDLE)
      begin
        tx_os_reg <= tx_os_reg + 4'h1;
        if (a_os_end && tx_state_reg == TX_DATA)
        begin
          tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
          tx_bit_reg   <= tx_bit_reg + 3'h1;
        end
      end
    end
  end

  // Asynchronous receive sequencer
  always_comb
  begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      RX_IDLE:
        if (rx_en && !err_any && !rxd_s)
          rx_state_next = RX_START;
      RX_START:
        if (a_tick && rx_os_reg == OS_MID)
          rx_state_next = rxd_s ? RX_IDLE : RX_DATA;
      RX_DATA:
        if (r_os_end && rx_bit_reg == LAST_BIT)
          rx_state_next = extra_on ? RX_EXTRA : RX_STOP;
      RX_EXTRA:
        if (r_os_end)
          rx_state_next = RX_STOP;
      RX_STOP:
        if (r_os_end)
          rx_state_next = RX_IDLE;
      default:
        rx_state_next = RX_IDLE;
    endcase
    if (!rx_en || sync_mode)
      rx_state_next = RX_IDLE;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_state_reg <= RX_IDLE;
      rx_os_reg    <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_extra_reg <= 1'b0;
      rx_shift_reg <= 8'h00;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      if (s_rise && rx_en)
        rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
      else if (rx_state_reg == RX_IDLE || (a_tick && rx_os_reg == OS_MID
               && rx_state_reg == RX_START))
      begin
        rx_os_reg  <= 4'h0;
        rx_bit_reg <= 3'h0;
      end
      else if (a_tick)
      begin
        rx_os_reg <= rx_os_reg + 4'h1;
        if (r_os_end && rx_state_reg == RX_DATA)
        begin
          rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
          rx_bit_reg   <= rx_bit_reg + 3'h1;
        end
        if (r_os_end && rx_state_reg == RX_EXTRA)
          rx_extra_reg <= rxd_s;
      end
      if (rx_state_reg == RX_IDLE && !extra_on)
        rx_extra_reg <= 1'b0;
    end
  end

  // Outputs
  assign o_rdata        = rdata_reg;
  assign o_txd          = txd_reg;
  assign o_sck          = sck_out_reg;
  assign o_sck_oe_b     = !clk_out;
  assign o_tx_empty_irq = serial_control_reg[CTRL_TXIE_BIT] && tx_buffer_empty_flag;
  assign o_tx_end_irq   = serial_control_reg[CTRL_TX_END_IRQ_EN_BIT] && tx_end_flag;
  assign o_rx_full_irq  = serial_control_reg[CTRL_RXIE_BIT] && rx_full_flag;
  assign o_rx_error_irq = serial_control_reg[CTRL_RXIE_BIT] && err_any;

endmodule

// *** tb/serial_channel_sva.sv ***
// Port checker for the serial channel
`timescale 1ns/1ns
module serial_channel_sva
  import serial_channel_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Requests
  input wire logic       o_tx_empty_irq,
  input wire logic       o_tx_end_irq,
  input wire logic       o_rx_full_irq,
  input wire logic       o_rx_error_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  wire rd_stat = i_rd && i_addr == ADDR_STATUS;
  property p_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  // A raised request must show its flag in the status read of the same cycle
  property p_txe;
    $past(rd_stat) && $past(o_tx_empty_irq) |-> o_rdata[STAT_TX_BUFFER_EMPTY_FLAG_BIT];
  endproperty
  a_txe: assert property (p_txe) else $error("empty request");
  property p_tx_end_flag;
    $past(rd_stat) && $past(o_tx_end_irq) |-> o_rdata[STAT_TX_END_FLAG_BIT];
  endproperty
  a_tx_end_flag: assert property (p_tx_end_flag) else $error("end request");
  property p_rxf;
    $past(rd_stat) && $past(o_rx_full_irq) |-> o_rdata[STAT_RX_FULL_FLAG_BIT];
  endproperty
  a_rxf: assert property (p_rxf) else $error("full request");
  property p_rxe;
    $past(rd_stat) && $past(o_rx_error_irq) |-> |o_rdata[5:3];
  endproperty
  a_rxe: assert property (p_rxe) else $error("error request");
  property p_wtx;
    i_wr && i_addr == ADDR_TXDATA ##1 rd_stat |=> !o_rdata[STAT_TX_BUFFER_EMPTY_FLAG_BIT] && !o_rdata[2];
  endproperty
  a_wtx: assert property (p_wtx) else $error("empty not cleared");
  property p_rrx;
    i_rd && i_addr == ADDR_RXDATA ##1 rd_stat |=> !o_rdata[STAT_RX_FULL_FLAG_BIT];
  endproperty
  a_rrx: assert property (p_rrx) else $error("full not cleared");
  property p_clr;
    i_wr && i_addr == ADDR_STATUS && !i_wdata[5] ##1 rd_stat |=> !o_rdata[STAT_OVR_BIT];
  endproperty
  a_clr: assert property (p_clr) else $error("overrun not cleared");
endmodule
bind serial_channel serial_channel_sva chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_tx_empty_irq(o_tx_empty_irq), .o_tx_end_irq(o_tx_end_irq),
  .o_rx_full_irq(o_rx_full_irq), .o_rx_error_irq(o_rx_error_irq));

// *** tb/serial_peer.sv ***
// Remote serial peer on the line side
`timescale 1ns/1ns
module serial_peer (
  // Clock and pins
  input  wire logic i_clk,
  input  wire logic i_sck,
  input  wire logic i_sck_oe_b,
  input  wire logic i_txd,
  output logic      o_sck,
  output logic      o_rxd
);
  logic [15:0] pat;
  logic [15:0] cap;
  int          n;
  initial
  begin
    o_sck = 1'b1;
    o_rxd = 1'b1;
    pat = 16'h0000;
    cap = 16'h0000;
    n = 0;
  end
  // Follow the device clock; ones once the pattern runs out (pull-up)
  always @(negedge i_sck)
    if (!i_sck_oe_b)
    begin
      o_rxd <= pat[0];
      pat <= {1'b1, pat[15:1]};
    end
  always @(posedge i_sck)
    if (!i_sck_oe_b)
    begin
      cap <= {i_txd, cap[15:1]};
      n <= n + 1;
    end
  // Clock a frame in; clock stands high outside frames
  task automatic sync_ext(input logic [7:0] d, output logic [7:0] q);
    for (int i = 0; i < 8; i++)
    begin
      o_sck <= 1'b0;
      o_rxd <= d[i];
      #40 o_sck <= 1'b1;
      #40 q[i] = i_txd;
    end
    o_rxd <= 1'b1;
  endtask
  // Sixteen clocks a bit at divisor 0
  task automatic send_async(input logic [7:0] d, input logic m, input logic s);
    logic [10:0] f;
    f = {s, m, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      o_rxd <= f[i];
      repeat (16) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
    repeat (16) @(posedge i_clk);
  endtask
endmodule

// *** tb/serial_channel_tb.sv ***
// Self-checking bench for the serial channel
`timescale 1ns/1ns
module serial_channel_tb;
  import serial_channel_pkg::*;
  logic       i_clk;
  logic       i_rst_b;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  logic       o_sck;
  logic       o_sck_oe_b;
  logic       o_txd;
  logic       o_tx_empty_irq;
  logic       o_tx_end_irq;
  logic       o_rx_full_irq;
  logic       o_rx_error_irq;
  wire        peer_sck;
  wire        rxd;
  wire        sck_line = o_sck_oe_b ? peer_sck : o_sck;
  logic [7:0] v;
  int         bad_count;
  int         checks;
  serial_channel dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck(sck_line), .o_sck(o_sck),
    .o_sck_oe_b(o_sck_oe_b), .i_rxd(rxd), .o_txd(o_txd), .o_tx_empty_irq(o_tx_empty_irq),
    .o_tx_end_irq(o_tx_end_irq), .o_rx_full_irq(o_rx_full_irq),
    .o_rx_error_irq(o_rx_error_irq));
  serial_peer peer (.i_clk(i_clk), .i_sck(sck_line), .i_sck_oe_b(o_sck_oe_b), .i_txd(o_txd),
    .o_sck(peer_sck), .o_rxd(rxd));
  always #5 i_clk = ~i_clk;
  task automatic stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Taken before the edge's updates: v holds the previous cycle's read data
  task automatic bus(input logic w, r, input logic [2:0] a, input logic [7:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    v = o_rdata;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic idle;
    repeat (4) bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] m, e, input string s);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    cmp(s, e, v & m);
  endtask
  task automatic poll(input int b);
    for (int k = 0; k < 500; k++)
    begin
      bus(1'b0, 1'b1, ADDR_STATUS, 8'h00);
      if (v[b] === 1'b1)
        return;
    end
    bad_count++;
    $display("BAD poll bit %0d exp 1 got 0", b);
    stop_test;
  endtask
  initial
  begin
    #500000;
    bad_count++;
    stop_test;
  end
  initial
  begin
    {i_clk, i_rst_b, i_addr, i_wdata, i_wr, i_rd, bad_count, checks} = '0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rdc(ADDR_STATUS, 8'hff, 8'h84, "reset status");
    rdc(3'h7, 8'hff, 8'h00, "unmapped");
    wr(ADDR_MODE, 8'h80);
    wr(ADDR_BAUD, 8'h03);
    peer.pat = 16'h5a96;
    wr(ADDR_CTRL, 8'hf4);
    wr(ADDR_TXDATA, 8'ha5);
    poll(STAT_TX_BUFFER_EMPTY_FLAG_BIT);
    cmp("empty irq", 8'h01, {7'h0, o_tx_empty_irq});
    wr(ADDR_TXDATA, 8'h3c);
    poll(STAT_RX_FULL_FLAG_BIT);
    cmp("full irq", 8'h01, {7'h0, o_rx_full_irq});
    rdc(ADDR_RXDATA, 8'hff, 8'h96, "rx first");
    poll(STAT_TX_END_FLAG_BIT);
    idle;
    rdc(ADDR_RXDATA, 8'hff, 8'h5a, "rx second");
    cmp("end irq", 8'h01, {7'h0, o_tx_end_irq});
    cmp("txd hold", 8'h00, {7'h0, o_txd});
    cmp("tx lo", 8'ha5, peer.cap[7:0]);
    cmp("tx hi", 8'h3c, peer.cap[15:8]);
    cmp("pulses", 8'h10, 8'(peer.n));
    cmp("sck idle", 8'h01, {7'h0, o_sck});
    cmp("sck drive", 8'h00, {7'h0, o_sck_oe_b});
    // External clock: receive-only overrun then refusal, then transmit and receive together
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h52);
    idle;
    cmp("sck input", 8'h01, {7'h0, o_sck_oe_b});
    peer.sync_ext(8'h11, v);
    peer.sync_ext(8'h22, v);
    idle;
    rdc(ADDR_STATUS, 8'hfc, 8'he4, "overrun");
    cmp("err irq", 8'h01, {7'h0, o_rx_error_irq});
    rdc(ADDR_RXDATA, 8'hff, 8'h11, "kept");
    idle;
    peer.sync_ext(8'h33, v);
    idle;
    rdc(ADDR_STATUS, 8'hfc, 8'ha4, "refused");
    wr(ADDR_CTRL, 8'h72);
    wr(ADDR_TXDATA, 8'h69);
    idle;
    peer.sync_ext(8'h00, v);
    idle;
    rdc(ADDR_STATUS, 8'hfc, 8'h20, "no start");
    wr(ADDR_STATUS, 8'h00);
    rdc(ADDR_STATUS, 8'h38, 8'h00, "cleared");
    idle;
    peer.sync_ext(8'h44, v);
    cmp("ext tx", 8'h69, v);
    idle;
    rdc(ADDR_RXDATA, 8'hff, 8'h44, "ext rx");
    // Asynchronous multiprocessor reception
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_CTRL, 8'h18);
    idle;
    peer.send_async(8'h77, 1'b0, 1'b1);
    rdc(ADDR_STATUS, 8'h78, 8'h00, "skip data");
    peer.send_async(8'h3a, 1'b1, 1'b1);
    rdc(ADDR_STATUS, 8'h42, 8'h42, "id frame");
    rdc(ADDR_CTRL, 8'hff, 8'h10, "wait off");
    rdc(ADDR_RXDATA, 8'hff, 8'h3a, "id");
    peer.send_async(8'h55, 1'b0, 1'b1);
    bus(1'b0, 1'b1, ADDR_RXDATA, 8'h00);
    rdc(ADDR_STATUS, 8'h40, 8'h00, "full cleared");
    rdc(ADDR_RXDATA, 8'hff, 8'h55, "data");
    peer.send_async(8'h0f, 1'b0, 1'b0);
    rdc(ADDR_STATUS, 8'h50, 8'h50, "framing");
    rdc(ADDR_RXDATA, 8'hff, 8'h0f, "framed data");
    stop_test;
  end
endmodule
